// File: include/sdc_pkg.sv
// Constants and types shared by the sample clock divider and sync logic
// Function
// - Divide sample clock by one through eight
// - Control bits choose every-pulse or single-shot realign
// - Accepted sync returns divider to initial state
// - Restorer gives nominal 50% internal clock
// - Restorer correction only guaranteed at or above 20 MHz
// - Sample taken on internal clock rising edge
// - Sync input passes internal synchronizer first
`default_nettype none
package sdc_pkg;
  // Register map
  localparam logic [12:0] SDC_CTRL_ADDR    = 13'h0100;
  localparam int          SDC_BIT_SYNC_EN  = 1;
  localparam int          SDC_BIT_SINGLE   = 2;
  localparam int          SDC_BIT_ARMED    = 3;
  localparam logic [7:0]  SDC_CTRL_RESET   = 8'h00;
  localparam logic [7:0]  SDC_CTRL_WMASK   = 8'h06;
  // Divider limits and reset value
  localparam int          SDC_RATIO_MAX    = 8;
  localparam logic [2:0]  SDC_RATIO_RESET  = 3'h0;
  // Clock and timing
  localparam int          SDC_CLK_HZ       = 50_000_000;
  localparam int          SDC_CLK_MHZ      = SDC_CLK_HZ / 1_000_000;
  localparam int          SDC_DCR_MIN_HZ   = 20_000_000;
  localparam int          SDC_RELOCK_NS    = 5000;
  localparam int          SDC_RELOCK_CYC   = (SDC_RELOCK_NS * SDC_CLK_MHZ + 999) / 1000;
  localparam logic [8:0]  SDC_LOCK_RESET   = 9'h000;
  // Single-shot arming state, Gray along off -> wait -> done
  typedef enum logic [1:0] {
    SDC_ARM_OFF  = 2'h0,
    SDC_ARM_WAIT = 2'h1,
    SDC_ARM_DONE = 2'h3
  } sdc_arm_t;
endpackage
`default_nettype wire

// File: rtl/sdc_sync_edge.sv
// Two-stage synchronizer with rising edge detect for the sync pin
`timescale 1ns/1ps
`default_nettype none
module sdc_sync_edge
(
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // Asynchronous pin and detected event
  input  wire logic i_async,
  output logic      o_rise
);
  // All state in one word
  typedef struct packed {
    logic meta;   // First stage, read only by second
    logic stab;   // Second stage
    logic prev;   // Delayed copy for edge detect
    logic rise;   // Registered event pulse
  } sdc_se_t;

  sdc_se_t s;
  sdc_se_t next_s;

  // Next state
  always_comb
  begin
    next_s      = s;
    next_s.meta = i_async;
    next_s.stab = s.meta;
    next_s.prev = s.stab;
    next_s.rise = s.stab & ~s.prev;
  end

  // State register
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      s <= '0;
    else
      s <= next_s;
  end

  assign o_rise = s.rise;

  // Event follows pin edge by exactly three edges
  property p_sync_delay;
    @(posedge i_clk) disable iff (i_rst)
    o_rise |-> $past(i_async, 3) && !$past(i_async, 4);
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("sync event without delayed pin edge");
endmodule
`default_nettype wire

// File: rtl/sdc_clock_divider.sv
// Sample clock divider with sync realignment and duty restorer
`timescale 1ns/1ps
`default_nettype none
module sdc_clock_divider
#(
  parameter int CLK_HZ = sdc_pkg::SDC_CLK_HZ
)
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // Sync pin, asynchronous
  input  wire logic       i_sync,
  // Divider setup: ratio minus one, restorer enable
  input  wire logic [2:0] i_div_sel,
  input  wire logic       i_dcr_enable,
  // Register port from serial decoder
  input  wire logic       i_reg_wr,
  input  wire logic [12:0] i_reg_addr,
  input  wire logic [7:0] i_reg_wdata,
  output logic [7:0]      o_reg_rdata,
  // Internal conversion clock and sample strobe
  output logic            o_conv_clk,
  output logic            o_sample,
  // Restorer settled
  output logic            o_dcr_locked
);
  // Restorer loop only usable at or above its minimum rate
  localparam bit DCR_OK = (CLK_HZ >= sdc_pkg::SDC_DCR_MIN_HZ);

  // Refuse a clock rate that cannot exist
  if (CLK_HZ <= 0)
  begin : g_bad_clk
    $error("CLK_HZ must be positive");
  end

  // Whole block state
  typedef struct packed {
    logic [7:0]       ctrl;      // Mode bits
    sdc_pkg::sdc_arm_t arm;      // Single-shot progress
    logic [2:0]       cnt;       // Divider phase, 0 is sampling edge
    logic [2:0]       ratio_m1;  // Ratio in use, minus one
    logic             conv_clk;  // Internal clock level
    logic             sample;    // Sampling edge pulse
    logic             dcr_q;     // Restorer enable, last cycle
    logic [8:0]       lock_cnt;  // Relock countdown
    logic             locked;    // Restorer settled
    logic [7:0]       rdata;     // Read data
  } sdc_st_t;

  sdc_st_t s;
  sdc_st_t next_s;
  logic    sync_rise;  // Synchronized sync edge
  logic    acc;        // Sync event taken this cycle
  logic    dcr_active; // Restorer in effect
  logic    wr_ctrl;    // Write to control register

  // High phase length in cycles for a given ratio
  function automatic logic [3:0] sdc_hi_len(input logic [2:0] rm1, input logic restore);
    logic [3:0] r;
    r = {1'b0, rm1} + 4'h1;
    if (restore)
      sdc_hi_len = (r + 4'h1) >> 1;
    else if (r == 4'h1)
      sdc_hi_len = 4'h1;
    else
      sdc_hi_len = r >> 1;
  endfunction

  // Sync pin conditioning
  sdc_sync_edge u_sync
  (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_async (i_sync),
    .o_rise  (sync_rise)
  );

  // Shared decode terms
  always_comb
  begin
    wr_ctrl    = i_reg_wr && (i_reg_addr == sdc_pkg::SDC_CTRL_ADDR);
    dcr_active = i_dcr_enable && DCR_OK;
    acc        = sync_rise && s.ctrl[sdc_pkg::SDC_BIT_SYNC_EN] &&
                 (!s.ctrl[sdc_pkg::SDC_BIT_SINGLE] || (s.arm == sdc_pkg::SDC_ARM_WAIT));
  end

  // Next state
  always_comb
  begin
    next_s        = s;
    next_s.sample = 1'b0;
    next_s.dcr_q  = dcr_active;

    if (acc && s.ctrl[sdc_pkg::SDC_BIT_SINGLE])
      next_s.arm = sdc_pkg::SDC_ARM_DONE;

    // Write rearms; wins over a same-cycle consumption
    if (wr_ctrl)
    begin
      next_s.ctrl = i_reg_wdata & sdc_pkg::SDC_CTRL_WMASK;
      if (i_reg_wdata[sdc_pkg::SDC_BIT_SINGLE])
        next_s.arm = sdc_pkg::SDC_ARM_WAIT;
      else
        next_s.arm = sdc_pkg::SDC_ARM_OFF;
    end

    if (acc)
    begin
      next_s.cnt      = 3'h0;
      next_s.ratio_m1 = i_div_sel;
      next_s.sample   = 1'b1;
    end
    else if (s.cnt == s.ratio_m1)
    begin
      next_s.cnt      = 3'h0;
      next_s.ratio_m1 = i_div_sel;
      next_s.sample   = 1'b1;
    end
    else
    begin
      next_s.cnt = s.cnt + 3'h1;
    end

    next_s.conv_clk = ({1'b0, next_s.cnt} < sdc_hi_len(next_s.ratio_m1, dcr_active));

    // Relock countdown after ratio change or enable; a new ratio is a new frequency
    if ((next_s.ratio_m1 != s.ratio_m1) || (dcr_active && !s.dcr_q))
      next_s.lock_cnt = 9'(sdc_pkg::SDC_RELOCK_CYC);
    else if (s.lock_cnt != 9'h000)
      next_s.lock_cnt = s.lock_cnt - 9'h001;
    next_s.locked = dcr_active && (next_s.lock_cnt == 9'h000);

    // Registered read, armed flag shows single-shot waiting
    next_s.rdata = 8'h00;
    if (i_reg_addr == sdc_pkg::SDC_CTRL_ADDR)
    begin
      next_s.rdata = s.ctrl;
      next_s.rdata[sdc_pkg::SDC_BIT_ARMED] = (s.arm == sdc_pkg::SDC_ARM_WAIT);
    end
  end

  // State register
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      s          <= '0;
      s.ctrl     <= sdc_pkg::SDC_CTRL_RESET;
      s.arm      <= sdc_pkg::SDC_ARM_OFF;
      s.ratio_m1 <= sdc_pkg::SDC_RATIO_RESET;
      s.lock_cnt <= sdc_pkg::SDC_LOCK_RESET;
    end
    else
    begin
      s <= next_s;
    end
  end

  // Outputs straight from state
  assign o_reg_rdata  = s.rdata;
  assign o_conv_clk   = s.conv_clk;
  assign o_sample     = s.sample;
  assign o_dcr_locked = s.locked;

  // Helper: period length between sampling edges
  logic [3:0] h_gap;
  logic [2:0] h_prev_rm1;
  logic       h_sync_seen;
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      h_gap       <= 4'h0;
      h_prev_rm1  <= 3'h0;
      h_sync_seen <= 1'b1;
    end
    else if (s.sample)
    begin
      h_gap       <= 4'h1;
      h_prev_rm1  <= s.ratio_m1;
      h_sync_seen <= acc;
    end
    else
    begin
      h_gap       <= (h_gap == 4'hf) ? h_gap : h_gap + 4'h1;
      h_sync_seen <= h_sync_seen | acc;
    end
  end

  property p_period;
    @(posedge i_clk) disable iff (i_rst)
    (s.sample && !h_sync_seen && !$past(acc)) |-> (h_gap == ({1'b0, h_prev_rm1} + 4'h1));
  endproperty
  a_period: assert property (p_period) else $error("sample spacing differs from ratio");

  property p_realign;
    @(posedge i_clk) disable iff (i_rst)
    acc |=> (s.cnt == 3'h0) && s.sample && (s.ratio_m1 == $past(i_div_sel));
  endproperty
  a_realign: assert property (p_realign) else $error("sync did not restart divider");

  property p_single_ignore;
    @(posedge i_clk) disable iff (i_rst)
    (sync_rise && (s.arm == sdc_pkg::SDC_ARM_DONE) && s.ctrl[sdc_pkg::SDC_BIT_SINGLE] && (s.cnt < s.ratio_m1))
      |=> (s.cnt == $past(s.cnt) + 3'h1);
  endproperty
  a_single_ignore: assert property (p_single_ignore) else $error("consumed single-shot still realigned");

  property p_single_consume;
    @(posedge i_clk) disable iff (i_rst)
    (acc && s.ctrl[sdc_pkg::SDC_BIT_SINGLE] && !wr_ctrl) |=> (s.arm == sdc_pkg::SDC_ARM_DONE);
  endproperty
  a_single_consume: assert property (p_single_consume) else $error("single-shot not consumed");

  property p_disabled_ignore;
    @(posedge i_clk) disable iff (i_rst)
    (sync_rise && !s.ctrl[sdc_pkg::SDC_BIT_SYNC_EN]) |-> !acc;
  endproperty
  a_disabled_ignore: assert property (p_disabled_ignore) else $error("sync taken while disabled");

  property p_duty_odd;
    @(posedge i_clk) disable iff (i_rst)
    (s.sample && dcr_active && (s.ratio_m1 == 3'h2) && (i_div_sel == 3'h2) && !acc) |=> s.conv_clk;
  endproperty
  a_duty_odd: assert property (p_duty_odd) else $error("restorer high phase too short");

  property p_duty_even;
    @(posedge i_clk) disable iff (i_rst)
    (s.sample && (s.ratio_m1 == 3'h3) && (i_div_sel == 3'h3) && !acc) |=> s.conv_clk ##1 (!s.conv_clk || $past(acc));
  endproperty
  a_duty_even: assert property (p_duty_even) else $error("ratio four not half duty");

  property p_lock_rate;
    @(posedge i_clk) disable iff (i_rst)
    s.locked |-> DCR_OK && $past(dcr_active);
  endproperty
  a_lock_rate: assert property (p_lock_rate) else $error("restorer locked below minimum rate");

  property p_edge_sample;
    @(posedge i_clk) disable iff (i_rst)
    s.sample |-> s.conv_clk && (s.cnt == 3'h0);
  endproperty
  a_edge_sample: assert property (p_edge_sample) else $error("sample not on rising clock phase");

  // Main scenarios
  c_realign: cover property (@(posedge i_clk) disable iff (i_rst) acc);
  c_single_done: cover property (@(posedge i_clk) disable iff (i_rst) s.arm == sdc_pkg::SDC_ARM_DONE);
  c_lock: cover property (@(posedge i_clk) disable iff (i_rst) $rose(s.locked));
  c_ratio8: cover property (@(posedge i_clk) disable iff (i_rst) s.sample && (s.ratio_m1 == 3'h7));
endmodule
`default_nettype wire

// File: tb/sdc_sync_source.sv
// Sync pin driver model on the sample clock side
`timescale 1ns/1ps
`default_nettype none
module sdc_sync_source
(
  // Source clock
  input  wire logic i_clk,
  // Request and slow answer select
  input  wire logic i_req,
  input  wire logic i_lag,
  // Sync pin
  output logic      o_sync
);
  logic stage = 1'b0;  // Extra stage for slow answer
  always @(posedge i_clk)
  begin
    stage  <= #1 i_req;
    o_sync <= #1 (i_lag ? stage : i_req);
  end
endmodule
`default_nettype wire

// File: tb/sample_clock_divider_sync_tb_top.sv
// Self-checking bench for the sample clock divider
`timescale 1ns/1ps
`default_nettype none
module sample_clock_divider_sync_tb_top;
  typedef struct {int cyc; logic [10:0] m; logic [10:0] v; string n;} sdc_note_t;
  localparam logic [10:0] RD = 11'h7f8;  // Read data field
  localparam logic [10:0] SM = 11'h004;  // Sample strobe
  localparam logic [10:0] CK = 11'h002;  // Conversion clock
  localparam logic [10:0] LK = 11'h001;  // Lock flag
  logic        i_clk        = 1'b0;
  logic        i_rst        = 1'b1;
  logic        req          = 1'b0;
  logic        lag          = 1'b0;
  logic        i_sync;
  logic [2:0]  i_div_sel    = 3'h0;
  logic        i_dcr_enable = 1'b0;
  logic        i_reg_wr     = 1'b0;
  logic [12:0] i_reg_addr   = 13'h0100;
  logic [7:0]  i_reg_wdata  = 8'h00;
  logic [7:0]  rnd          = 8'h27;  // Random state
  logic [7:0]  o_reg_rdata;
  logic        o_conv_clk;
  logic        o_sample;
  logic        o_dcr_locked;
  int          cyc          = 0;
  int          bad_count    = 0;
  int          comparisons  = 0;
  int          s;                     // Expected realign cycle
  int          sa           = 17;     // Last realign cycle
  int          nr           = 1;      // Current ratio
  sdc_note_t   q[$];                  // Pending expectations
  always #10 i_clk = ~i_clk;
  sdc_clock_divider #(.CLK_HZ(sdc_pkg::SDC_CLK_HZ)) dut (.i_clk(i_clk), .i_rst(i_rst), .i_sync(i_sync),
    .i_div_sel(i_div_sel), .i_dcr_enable(i_dcr_enable), .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_conv_clk(o_conv_clk), .o_sample(o_sample),
    .o_dcr_locked(o_dcr_locked));
  sdc_sync_source src (.i_clk(i_clk), .i_req(req), .i_lag(lag), .o_sync(i_sync));
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic tick(input int k);
    repeat (k) @(posedge i_clk);
    #1;
  endtask
  task automatic note(input int d, input logic [10:0] m, input logic [10:0] v, input string n);
    q.push_back('{cyc + d, m, v, n});
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] d, input logic [7:0] e);
    i_reg_wr = 1'b1;
    i_reg_addr = a;
    i_reg_wdata = d;
    tick(1);
    i_reg_wr = 1'b0;
    i_reg_addr = 13'h0100;
    note(1, RD, {e, 3'h0}, "ctrl");
    rnd = lfsr(rnd);
    tick(1);
  endtask
  task automatic rd(input logic [12:0] a, input logic [7:0] e);
    i_reg_addr = a;
    note(1, RD, {e, 3'h0}, "rdata");
    tick(1);
  endtask
  // Pulse held four edges; returns on the realign edge
  task automatic sync_go(input logic acc);
    lag = rnd[0];
    rnd = lfsr(rnd);
    req = 1'b1;
    s = cyc + 5 + lag;
    note(5 + lag, SM, {8'h00, acc || ((s - sa) % nr == 0), 2'h0}, "sample");
    if (acc)
      sa = s;
    tick(4);
    req = 1'b0;
    tick(1 + lag);
  endtask
  task automatic close_out();
    $display("counts: comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Cycle count and hang limit
  always @(posedge i_clk)
  begin
    cyc <= cyc + 1;
    if (cyc > 2000)
    begin
      bad_count++;
      close_out();
    end
  end
  // Monitor takes due notes on settled outputs
  always @(negedge i_clk)
  begin
    for (int i = q.size() - 1; i >= 0; i--)
      if (q[i].cyc == cyc)
      begin
        comparisons++;
        if (({o_reg_rdata, o_sample, o_conv_clk, o_dcr_locked} & q[i].m) !== q[i].v)
        begin
          bad_count++;
          $display("mismatch %s expected %h seen %h", q[i].n, q[i].v,
            {o_reg_rdata, o_sample, o_conv_clk, o_dcr_locked} & q[i].m);
        end
        q.delete(i);
      end
  end
  initial
  begin
    note(10, RD | SM | CK | LK, 11'h000, "reset");
    tick(16);
    i_rst = 1'b0;
    note(1, SM | CK, 11'h006, "release");
    rd(13'h0100, 8'h00);
    rd(13'h0101, 8'h00);
    rd(13'h1fff, 8'h00);
    wr(13'h0000, 8'hff, 8'h00);
    $display("test registers done");
    wr(13'h0100, {rnd[7:3], 3'h2}, 8'h02);
    // Every ratio realigned then timed
    for (int n = 1; n <= 8; n++)
    begin
      i_div_sel = 3'(n - 1);
      nr = n;
      sync_go(1'b1);
      note(0, CK, 11'h002, "clk");
      note(n, SM | CK, 11'h006, "period");
      if (n > 1)
      begin
        note(n - 1, SM, 11'h000, "gap");
        note(n / 2 > 1 ? n / 2 : 1, CK, 11'h000, "duty");
      end
      tick(n);
    end
    $display("test ratios done");
    wr(13'h0100, 8'hff, 8'h0e);
    sync_go(1'b1);
    rd(13'h0100, 8'h06);
    sync_go(1'b0);
    wr(13'h0100, {rnd[7:3], 3'h6}, 8'h0e);
    sync_go(1'b1);
    wr(13'h0100, {rnd[7:3], 3'h0}, 8'h00);
    sync_go(1'b0);
    $display("test sync modes done");
    wr(13'h0100, 8'h02, 8'h02);
    i_div_sel = 3'h2;
    nr = 3;
    sync_go(1'b1);
    i_dcr_enable = 1'b1;
    note(sdc_pkg::SDC_RELOCK_CYC, LK, 11'h000, "unlocked");
    note(sdc_pkg::SDC_RELOCK_CYC + 1, LK, 11'h001, "locked");
    tick(301);
    sync_go(1'b1);
    note(0, CK | LK, 11'h003, "high0");
    note(1, CK, 11'h002, "high1");
    note(2, CK, 11'h000, "low");
    note(3, SM | CK, 11'h006, "next");
    tick(5);
    $display("test restorer done");
    close_out();
  end
endmodule
`default_nettype wire
